//--- src/msc_regs.svh
`ifndef MSC_REGS_SVH
`define MSC_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define MSC_ADDR_CFG0 8'h00
`define MSC_ADDR_CYCLE 8'h04
`define MSC_ADDR_CFG2 8'h08
`define MSC_ADDR_CMD 8'h0c
`define MSC_ADDR_STAT 8'h10
`define MSC_ADDR_RESULT 8'h14

// ****************************************
// Field positions
// ****************************************
`define MSC_CFG0_TEMP_LSB 0
`define MSC_CFG0_ONESHOT 2
`define MSC_CFG0_OFFS_SUB 7
`define MSC_CFG0_WARM_LSB 8
`define MSC_CFG0_FAKE_LSB 11
`define MSC_CFG0_SPD1_LSB 13
`define MSC_CFG0_SPD2_LSB 15
`define MSC_CFG2_AVG_LSB 4
`define MSC_STAT_DSPERR 19
`define MSC_STAT_TIMEOUT 20
`define MSC_STAT_OVERRUN 21
`define MSC_STAT_BUSY 22
`define MSC_STAT_INT 23

// ****************************************
// Reset values and opcodes
// ****************************************
`define MSC_CFG0_RST 32'h0000a000
`define MSC_CYCLE_RST 16'h0100
`define MSC_CFG2_RST 32'h00000000
`define MSC_OP_INIT 8'hc0
`define MSC_OP_START 8'hcc

// ****************************************
// Timing and counts
// ****************************************
`define MSC_CLK_NS 20
`define MSC_MIN_DISCH_NS 1500
`define MSC_MIN_DISCH_CYC ((`MSC_MIN_DISCH_NS + `MSC_CLK_NS - 1) / `MSC_CLK_NS)
`define MSC_TEMP_FRAC 14
`define MSC_TEMP_MOD_A 4'h6
`define MSC_TEMP_MOD_B 4'h9
`define MSC_WARM_BASE 11'h010

`endif

//--- src/msc_pkg.sv
package msc_pkg;
	typedef enum logic [3:0] {
		PH_WARM = 4'b0001,
		PH_FAKE = 4'b0010,
		PH_OFFS = 4'b0100,
		PH_MEAS = 4'b1000
	} msc_phase_e;

	typedef enum logic [4:0] {
		SL_IDLE = 5'b00001,
		SL_SG = 5'b00010,
		SL_T1 = 5'b00100,
		SL_T2 = 5'b01000,
		SL_WAIT = 5'b10000
	} msc_slot_e;

	typedef enum logic [1:0] {
		TK_SG = 2'h0,
		TK_TSENS = 2'h1,
		TK_TREF = 2'h2
	} msc_kind_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} msc_bus_s;

	typedef struct packed {
		logic start;
		msc_kind_e kind;
	} msc_tdc_req_s;

	typedef struct packed {
		logic done;
		logic [23:0] value;
	} msc_tdc_rsp_s;
endpackage : msc_pkg

//--- src/msc_ratio_div.sv
`timescale 1ns/1ps
`include "msc_regs.svh"
module msc_ratio_div (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Operands
	input wire logic start,
	input wire logic [15:0] num,
	input wire logic [15:0] den,
	// Result
	output logic done,
	output logic [15:0] ratio
);
	import msc_pkg::*;

	logic run, next_run, next_done;
	logic [4:0] cnt, next_cnt;
	logic [29:0] dvd, next_dvd, quo, next_quo;
	logic [16:0] rem, next_rem;
	logic [15:0] dsr, next_dsr, next_ratio;

	always_comb begin
		logic [16:0] sh;
		sh = {rem[15:0], dvd[29]};
		next_run = run;
		next_cnt = cnt;
		next_dvd = dvd;
		next_quo = quo;
		next_rem = rem;
		next_dsr = dsr;
		next_done = 1'b0;
		next_ratio = ratio;
		if (start) begin
			next_run = 1'b1;
			next_cnt = 5'h1d;
			next_dvd = {num, 14'h0000};
			next_quo = 30'h0;
			next_rem = 17'h0;
			next_dsr = den;
		end else if (run) begin
			next_dvd = {dvd[28:0], 1'b0};
			if (sh >= {1'b0, dsr}) begin
				next_rem = sh - {1'b0, dsr};
				next_quo = {quo[28:0], 1'b1};
			end else begin
				next_rem = sh;
				next_quo = {quo[28:0], 1'b0};
			end
			next_cnt = cnt - 5'h01;
			if (cnt == 5'h00) begin
				next_run = 1'b0;
				next_done = 1'b1;
				// A ratio of four or more cannot be shown in 2.14, so it saturates
				if (dsr == 16'h0000 || next_quo[29:16] != 14'h0000) begin
					next_ratio = 16'hffff;
				end else begin
					next_ratio = next_quo[15:0];
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			run <= 1'b0;
			cnt <= 5'h00;
			dvd <= 30'h0;
			quo <= 30'h0;
			rem <= 17'h0;
			dsr <= 16'h0000;
			done <= 1'b0;
			ratio <= 16'h0000;
		end else begin
			run <= next_run;
			cnt <= next_cnt;
			dvd <= next_dvd;
			quo <= next_quo;
			rem <= next_rem;
			dsr <= next_dsr;
			done <= next_done;
			ratio <= next_ratio;
		end
	end
endmodule : msc_ratio_div

//--- src/msc_seq.sv
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "msc_regs.svh"
module msc_seq (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Register port
	input wire msc_pkg::msc_bus_s bus,
	output logic [31:0] rdata,
	// Time-measuring unit
	output msc_pkg::msc_tdc_req_s tdc_req,
	input wire msc_pkg::msc_tdc_rsp_s tdc_rsp,
	// Arithmetic units
	input wire logic alu1_ram_req,
	input wire logic alu2_ram_req,
	output logic [1:0] first_arith_unit_speed,
	output logic [1:0] second_arith_unit_speed,
	// Status
	output logic int_flag,
	output logic busy
);
	import msc_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic msc_phase_e pick_from(input msc_phase_e from, input logic [2:0] warm,
		input logic [1:0] fake, input logic sub);
		pick_from = PH_MEAS;
		if (from == PH_WARM && warm != 3'h0) begin
			pick_from = PH_WARM;
		end else if ((from == PH_WARM || from == PH_FAKE) && fake != 2'h0) begin
			pick_from = PH_FAKE;
		end else if (from != PH_MEAS && sub) begin
			pick_from = PH_OFFS;
		end
	endfunction : pick_from

	function automatic logic [10:0] cnt_load(input msc_phase_e ph, input logic [2:0] warm,
		input logic [1:0] fake, input logic [2:0] avg);
		case (ph)
			PH_WARM: cnt_load = `MSC_WARM_BASE << (warm - 3'h1);
			PH_FAKE: cnt_load = (fake == 2'h3) ? 11'h004 : {9'h000, fake};
			PH_OFFS: cnt_load = 11'h001 << avg;
			default: cnt_load = 11'h000;
		endcase
	endfunction : cnt_load

	// ****************************************
	// Register file
	// ****************************************
	logic [31:0] cfg0, next_cfg0, cfg2, next_cfg2, next_rdata;
	logic [15:0] cycle_cnt, next_cycle_cnt;
	logic init_cmd, start_cmd, stat_rd, res_rd;
	logic dsp_err, timeout, overrun, active;
	logic [15:0] temp_ratio;
	logic [23:0] result;

	wire [1:0] temp_sel = cfg0[`MSC_CFG0_TEMP_LSB +: 2];
	wire one_shot_conversion = cfg0[`MSC_CFG0_ONESHOT];
	wire offset_subtract_en = cfg0[`MSC_CFG0_OFFS_SUB];
	wire [2:0] warm_sel = cfg0[`MSC_CFG0_WARM_LSB +: 3];
	wire [1:0] fake_sel = cfg0[`MSC_CFG0_FAKE_LSB +: 2];
	wire [2:0] offset_average_count = cfg2[`MSC_CFG2_AVG_LSB +: 3];

	assign init_cmd = bus.wr && bus.addr == `MSC_ADDR_CMD && bus.wdata[7:0] == `MSC_OP_INIT;
	assign start_cmd = bus.wr && bus.addr == `MSC_ADDR_CMD && bus.wdata[7:0] == `MSC_OP_START;
	assign stat_rd = bus.rd && bus.addr == `MSC_ADDR_STAT;
	assign res_rd = bus.rd && bus.addr == `MSC_ADDR_RESULT;
	assign first_arith_unit_speed = cfg0[`MSC_CFG0_SPD1_LSB +: 2];
	assign second_arith_unit_speed = cfg0[`MSC_CFG0_SPD2_LSB +: 2];

	always_comb begin
		next_cfg0 = cfg0;
		next_cfg2 = cfg2;
		next_cycle_cnt = cycle_cnt;
		next_rdata = 32'h0;
		if (bus.wr) begin
			case (bus.addr)
				`MSC_ADDR_CFG0: next_cfg0 = bus.wdata;
				`MSC_ADDR_CYCLE: next_cycle_cnt = bus.wdata[15:0];
				`MSC_ADDR_CFG2: next_cfg2 = bus.wdata;
				default: next_cfg0 = cfg0;
			endcase
		end
		if (bus.rd) begin
			case (bus.addr)
				`MSC_ADDR_CFG0: next_rdata = cfg0;
				`MSC_ADDR_CYCLE: next_rdata = {16'h0000, cycle_cnt};
				`MSC_ADDR_CFG2: next_rdata = cfg2;
				`MSC_ADDR_STAT: begin
					next_rdata[15:0] = temp_ratio;
					next_rdata[`MSC_STAT_DSPERR] = dsp_err;
					next_rdata[`MSC_STAT_TIMEOUT] = timeout;
					next_rdata[`MSC_STAT_OVERRUN] = overrun;
					next_rdata[`MSC_STAT_BUSY] = active;
					next_rdata[`MSC_STAT_INT] = int_flag;
				end
				`MSC_ADDR_RESULT: next_rdata = {{8{result[23]}}, result};
				default: next_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cfg0 <= `MSC_CFG0_RST;
			cfg2 <= `MSC_CFG2_RST;
			cycle_cnt <= `MSC_CYCLE_RST;
			rdata <= 32'h0;
		end else begin
			cfg0 <= next_cfg0;
			cfg2 <= next_cfg2;
			cycle_cnt <= next_cycle_cnt;
			rdata <= next_rdata;
		end
	end

	// ****************************************
	// Measurement sequencer
	// ****************************************
	msc_phase_e phase, next_phase;
	msc_slot_e slot, next_slot;
	msc_tdc_req_s next_tdc;
	logic next_active, fresh, next_fresh, tdue, next_tdue, next_int;
	logic next_dsp_err, next_timeout, next_overrun, div_start, next_div_start;
	logic tick, slot_end, div_done;
	logic [15:0] cyc, next_cyc, period_last, t1_val, next_t1, t2_val, next_t2;
	logic [15:0] div_ratio, next_temp_ratio;
	logic [10:0] cnt, next_cnt;
	logic [3:0] temp_cnt, next_temp_cnt;
	logic [23:0] sg_val, next_sg, offset, next_offset, next_result;
	logic [31:0] acc, next_acc;

	// A period of zero would wrap to 65536 cycles, so it behaves like one
	assign period_last = (cycle_cnt == 16'h0000) ? 16'h0000 : cycle_cnt - 16'h0001;
	assign tick = active && cyc == period_last;

	always_comb begin
		logic [23:0] end_sg;
		logic [31:0] sum;
		logic [3:0] tmod;
		msc_phase_e nph;
		end_sg = (slot == SL_SG) ? tdc_rsp.value : sg_val;
		sum = acc + {{8{end_sg[23]}}, end_sg};
		tmod = (temp_sel == 2'h2) ? `MSC_TEMP_MOD_A : `MSC_TEMP_MOD_B;
		nph = phase;
		next_phase = phase;
		next_slot = slot;
		next_active = active;
		next_fresh = fresh;
		next_cnt = cnt;
		next_cyc = (!active || tick) ? 16'h0000 : cyc + 16'h0001;
		next_tdc = '{start: 1'b0, kind: tdc_req.kind};
		next_tdue = tdue;
		next_temp_cnt = temp_cnt;
		next_t1 = t1_val;
		next_t2 = t2_val;
		next_sg = sg_val;
		next_acc = acc;
		next_offset = offset;
		next_result = result;
		next_div_start = 1'b0;
		next_temp_ratio = div_done ? div_ratio : temp_ratio;
		next_int = int_flag && !res_rd;
		next_timeout = timeout && !stat_rd;
		next_overrun = overrun && !stat_rd;
		next_dsp_err = (dsp_err && !stat_rd) || (alu1_ram_req && alu2_ram_req);
		slot_end = 1'b0;
		if (start_cmd && !active) begin
			next_active = 1'b1;
			next_cyc = period_last;
			if (fresh) begin
				nph = pick_from(PH_WARM, warm_sel, fake_sel, offset_subtract_en);
				next_phase = nph;
				next_cnt = cnt_load(nph, warm_sel, fake_sel, offset_average_count);
				next_fresh = 1'b0;
			end
		end
		if (tick) begin
			// An unfinished slot is dropped so no slot ever spans two cycles
			if (slot != SL_WAIT && slot != SL_IDLE) begin
				next_overrun = 1'b1;
			end
			next_slot = SL_SG;
			next_tdc = '{start: 1'b1, kind: TK_SG};
			next_tdue = 1'b0;
			if (phase == PH_OFFS || phase == PH_MEAS) begin
				next_tdue = temp_sel == 2'h1 || (temp_sel != 2'h0 && temp_cnt == 4'h0);
				next_temp_cnt = (temp_cnt >= tmod - 4'h1) ? 4'h0 : temp_cnt + 4'h1;
			end
		end else begin
			case (slot)
				SL_SG: if (tdc_rsp.done) begin
					next_sg = tdc_rsp.value;
					if (tdue) begin
						next_slot = SL_T1;
						next_tdc = '{start: 1'b1, kind: TK_TSENS};
					end else begin
						slot_end = 1'b1;
					end
				end
				SL_T1: if (tdc_rsp.done) begin
					next_t1 = tdc_rsp.value[15:0];
					next_slot = SL_T2;
					next_tdc = '{start: 1'b1, kind: TK_TREF};
					if (tdc_rsp.value < 24'(`MSC_MIN_DISCH_CYC)) begin
						next_timeout = 1'b1;
					end
				end
				SL_T2: if (tdc_rsp.done) begin
					next_t2 = tdc_rsp.value[15:0];
					next_div_start = 1'b1;
					slot_end = 1'b1;
					if (tdc_rsp.value < 24'(`MSC_MIN_DISCH_CYC)) begin
						next_timeout = 1'b1;
					end
				end
				default: next_slot = slot;
			endcase
		end
		if (slot_end) begin
			next_slot = SL_WAIT;
			case (phase)
				PH_WARM, PH_FAKE: begin
					// No result and no flag from these slots
					if (cnt <= 11'h001) begin
						nph = pick_from((phase == PH_WARM) ? PH_FAKE : PH_OFFS, warm_sel,
							fake_sel, offset_subtract_en);
						next_phase = nph;
						next_cnt = cnt_load(nph, warm_sel, fake_sel, offset_average_count);
					end else begin
						next_cnt = cnt - 11'h001;
					end
				end
				PH_OFFS: begin
					next_acc = sum;
					if (cnt <= 11'h001) begin
						next_offset = 24'($signed(sum) >>> offset_average_count);
						next_phase = PH_MEAS;
					end else begin
						next_cnt = cnt - 11'h001;
					end
					if (one_shot_conversion) begin
						next_active = 1'b0;
						next_slot = SL_IDLE;
					end
				end
				PH_MEAS: begin
					next_result = end_sg - (offset_subtract_en ? offset : 24'h000000);
					next_int = 1'b1;
					if (one_shot_conversion) begin
						next_active = 1'b0;
						next_slot = SL_IDLE;
					end
				end
				default: next_phase = PH_MEAS;
			endcase
		end
		if (init_cmd) begin
			next_active = 1'b0;
			next_slot = SL_IDLE;
			next_fresh = 1'b1;
			next_acc = 32'h0;
			next_offset = 24'h000000;
			next_temp_cnt = 4'h0;
			next_tdc = '{start: 1'b0, kind: TK_SG};
			next_div_start = 1'b0;
			next_int = int_flag && !res_rd;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			phase <= PH_MEAS;
			slot <= SL_IDLE;
			active <= 1'b0;
			fresh <= 1'b1;
			cnt <= 11'h000;
			cyc <= 16'h0000;
			tdc_req <= '{start: 1'b0, kind: TK_SG};
			tdue <= 1'b0;
			temp_cnt <= 4'h0;
			t1_val <= 16'h0000;
			t2_val <= 16'h0000;
			sg_val <= 24'h000000;
			acc <= 32'h0;
			offset <= 24'h000000;
			result <= 24'h000000;
			div_start <= 1'b0;
			temp_ratio <= 16'h0000;
			int_flag <= 1'b0;
			timeout <= 1'b0;
			overrun <= 1'b0;
			dsp_err <= 1'b0;
			busy <= 1'b0;
		end else begin
			phase <= next_phase;
			slot <= next_slot;
			active <= next_active;
			fresh <= next_fresh;
			cnt <= next_cnt;
			cyc <= next_cyc;
			tdc_req <= next_tdc;
			tdue <= next_tdue;
			temp_cnt <= next_temp_cnt;
			t1_val <= next_t1;
			t2_val <= next_t2;
			sg_val <= next_sg;
			acc <= next_acc;
			offset <= next_offset;
			result <= next_result;
			div_start <= next_div_start;
			temp_ratio <= next_temp_ratio;
			int_flag <= next_int;
			timeout <= next_timeout;
			overrun <= next_overrun;
			dsp_err <= next_dsp_err;
			busy <= next_active;
		end
	end

	msc_ratio_div u_div (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.start(div_start),
		.num(t1_val),
		.den(t2_val),
		.done(div_done),
		.ratio(div_ratio)
	);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	chk_temp_off: assert property (tdc_req.start && tdc_req.kind == TK_TSENS |-> temp_sel != 2'h0)
		else $error("temperature started while disabled");
	chk_temp_unit: assert property (tdc_req.start && tdc_req.kind == TK_TSENS |-> $past(slot) == SL_SG)
		else $error("temperature not following strain");
	chk_short_disch: assert property (slot == SL_T1 && tdc_rsp.done && !tick
		&& tdc_rsp.value < 24'(`MSC_MIN_DISCH_CYC) |=> timeout)
		else $error("short discharge not flagged");
	chk_slot_bound: assert property (tick && !init_cmd
		|=> slot == SL_SG && tdc_req.start && tdc_req.kind == TK_SG)
		else $error("slot not restarted on cycle tick");
	chk_offs_quiet: assert property (slot_end && phase == PH_OFFS && !init_cmd && !res_rd
		|=> int_flag == $past(int_flag))
		else $error("offset measurement raised flag");
	chk_fake_silent: assert property (slot_end && phase == PH_FAKE |=> $stable(result))
		else $error("fake measurement changed result");
	chk_ram_clash: assert property (alu1_ram_req && alu2_ram_req |=> dsp_err ##1 rdata[19] || !$past(stat_rd))
		else $error("RAM collision not flagged");
	chk_init_stop: assert property (init_cmd && !int_flag |=> !active && slot == SL_IDLE && !int_flag)
		else $error("init did not stop quietly");
	chk_oneshot_idle: assert property (slot_end && phase == PH_MEAS && one_shot_conversion && !init_cmd
		|=> int_flag && !active)
		else $error("one-shot did not flag and idle");
	chk_cycle_wrap: assert property (tick && !init_cmd |=> cyc == 16'h0000)
		else $error("cycle counter did not wrap");

	cov_temp_done: cover property (slot == SL_T2 && tdc_rsp.done);
	cov_offset_done: cover property (slot_end && phase == PH_OFFS && cnt == 11'h001);
	cov_meas_flag: cover property (slot_end && phase == PH_MEAS);
	cov_overrun: cover property (tick && slot == SL_T1);
endmodule : msc_seq

//--- tb/msc_tdc_model.sv
`timescale 1ns/1ps
// ****************************************
// Time-measuring unit stand-in
// ****************************************
module msc_tdc_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Request from the sequencer
	input wire msc_pkg::msc_tdc_req_s tdc_req,
	// Behaviour set by the bench
	input wire logic [7:0] lat,
	input wire logic [23:0] val_sg,
	input wire logic [23:0] val_ts,
	input wire logic [23:0] val_tr,
	// Answer
	output msc_pkg::msc_tdc_rsp_s tdc_rsp
);
	import msc_pkg::*;
	logic pend;
	logic [7:0] cnt;
	msc_kind_e kind;

	// Value toggles between answers so a stale sample never looks valid
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pend <= 1'b0;
			cnt <= 8'h00;
			kind <= TK_SG;
			tdc_rsp <= '0;
		end else begin
			tdc_rsp.done <= 1'b0;
			tdc_rsp.value <= ~tdc_rsp.value;
			if (tdc_req.start) begin
				pend <= 1'b1;
				cnt <= lat;
				kind <= tdc_req.kind;
			end else if (pend && cnt == 8'h00) begin
				pend <= 1'b0;
				tdc_rsp.done <= 1'b1;
				case (kind)
					TK_SG: tdc_rsp.value <= val_sg;
					TK_TSENS: tdc_rsp.value <= val_ts;
					default: tdc_rsp.value <= val_tr;
				endcase
			end else if (pend) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule : msc_tdc_model

//--- tb/msc_seq_test.sv
`timescale 1ns/1ps
`include "msc_regs.svh"
module msc_seq_test;
	import msc_pkg::*;
	localparam int PERIOD = 40;
	logic ref_clk;
	logic rstn;
	msc_bus_s bus;
	logic [31:0] rdata;
	msc_tdc_req_s tdc_req;
	msc_tdc_rsp_s tdc_rsp;
	logic alu1_ram_req;
	logic alu2_ram_req;
	logic [1:0] spd1;
	logic [1:0] spd2;
	logic int_flag;
	logic busy;
	logic [7:0] lat;
	logic [23:0] val_sg;
	logic [23:0] val_ts;
	logic [23:0] val_tr;
	logic [31:0] ratio;
	logic rd_pend;
	logic [31:0] q_mask[$];
	logic [31:0] q_exp[$];
	int n_mismatch;
	int compares;
	int n_sg;
	int n_ts;
	int cyc;
	int last_sg;
	int sg_gap;
	int held;
	int r;
	int t_exp[4] = '{0, 18, 3, 2};

	msc_seq u_msc_seq (.ref_clk(ref_clk), .rstn(rstn), .bus(bus), .rdata(rdata),
		.tdc_req(tdc_req), .tdc_rsp(tdc_rsp), .alu1_ram_req(alu1_ram_req),
		.alu2_ram_req(alu2_ram_req), .first_arith_unit_speed(spd1),
		.second_arith_unit_speed(spd2), .int_flag(int_flag), .busy(busy));
	msc_tdc_model u_msc_tdc_model (.ref_clk(ref_clk), .rstn(rstn), .tdc_req(tdc_req),
		.lat(lat), .val_sg(val_sg), .val_ts(val_ts), .val_tr(val_tr), .tdc_rsp(tdc_rsp));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// ****************************************
	// Bench tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_of_test;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test

	// Step past the edge so registered outputs have settled
	task automatic tick;
		@(posedge ref_clk);
		#1;
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge ref_clk);
		bus.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		q_mask.push_back(m);
		q_exp.push_back(e & m);
		@(posedge ref_clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge ref_clk);
		bus.rd <= 1'b0;
	endtask : rd

	// Zero waits for the flag, one waits for the sequencer to go idle
	task automatic wait_for(input int what);
		int k;
		for (k = 0; k < 3000; k++) begin
			tick;
			if (what == 0 && int_flag === 1'b1) break;
			if (what == 1 && busy === 1'b0) break;
		end
	endtask : wait_for

	// ****************************************
	// Watchers
	// ****************************************
	always @(posedge ref_clk) begin
		cyc++;
		if (tdc_req.start === 1'b1 && tdc_req.kind == TK_SG) begin
			sg_gap = cyc - last_sg;
			last_sg = cyc;
			n_sg++;
		end
		if (tdc_req.start === 1'b1 && tdc_req.kind == TK_TSENS) n_ts++;
	end

	always @(posedge ref_clk) begin
		if (rd_pend && q_exp.size() > 0) check(rdata & q_mask.pop_front(), q_exp.pop_front());
		rd_pend = bus.rd;
	end

	initial begin
		repeat (60000) @(posedge ref_clk);
		n_mismatch++;
		end_of_test;
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		bus = '0;
		rstn = 1'b0;
		alu1_ram_req = 1'b0;
		alu2_ram_req = 1'b0;
		lat = 8'h03;
		{n_mismatch, compares, n_sg, n_ts, cyc, last_sg, sg_gap} = '0;
		rd_pend = 1'b0;
		void'($urandom(32'h5141));
		val_sg = 24'(($urandom % 1000) + 1);
		val_ts = 24'(($urandom % 1500) + 100);
		val_tr = 24'(($urandom % 1000) + 1000);
		ratio = 32'((64'(val_ts) << 14) / 64'(val_tr));
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		tick;
		check(32'(spd1), 32'h1);
		check(32'(spd2), 32'h1);
		rd(`MSC_ADDR_CFG0, 32'hffffffff, `MSC_CFG0_RST);
		rd(`MSC_ADDR_CYCLE, 32'h0000ffff, 32'(`MSC_CYCLE_RST));
		rd(8'h20, 32'hffffffff, 32'h0);
		rd(`MSC_ADDR_STAT, 32'h00c00000, 32'h0);
		// Warm-up of 16, four fakes, then the first normal slot
		wr(`MSC_ADDR_CYCLE, 32'(PERIOD));
		wr(`MSC_ADDR_CFG0, `MSC_CFG0_RST | 32'h00001901);
		wr(`MSC_ADDR_CMD, 32'(`MSC_OP_START));
		wait_for(0);
		check(32'(n_sg), 32'd21);
		check(32'(n_ts), 32'h1);
		repeat (3 * PERIOD) tick;
		check(32'(sg_gap), 32'(PERIOD));
		rd(`MSC_ADDR_STAT, 32'h0030ffff, ratio);
		// Shared RAM: both units at once is a collision, cleared by a status read
		@(posedge ref_clk);
		alu1_ram_req <= 1'b1;
		@(posedge ref_clk);
		alu2_ram_req <= 1'b1;
		@(posedge ref_clk);
		alu1_ram_req <= 1'b0;
		alu2_ram_req <= 1'b0;
		rd(`MSC_ADDR_STAT, 32'h00080000, 32'h00080000);
		rd(`MSC_ADDR_STAT, 32'h00080000, 32'h0);
		// Discharge time at and just under the limit
		val_ts <= 24'd75;
		repeat (2 * PERIOD) tick;
		rd(`MSC_ADDR_STAT, 32'h00100000, 32'h0);
		val_ts <= 24'd74;
		repeat (2 * PERIOD) tick;
		rd(`MSC_ADDR_STAT, 32'h00100000, 32'h00100000);
		// Answers slower than one cycle get their slot dropped
		lat <= 8'h30;
		repeat (2 * PERIOD) tick;
		rd(`MSC_ADDR_STAT, 32'h00200000, 32'h00200000);
		lat <= 8'h03;
		// Init in mid-run stops slots and raises no flag
		wr(`MSC_ADDR_CMD, 32'(`MSC_OP_INIT));
		rd(`MSC_ADDR_RESULT, 32'hffffffff, 32'(val_sg));
		held = n_sg;
		repeat (3 * PERIOD) tick;
		check(32'(busy), 32'h0);
		check(32'(int_flag), 32'h0);
		check(32'(n_sg), 32'(held));
		// Every interval setting, counted over 18 strain slots
		for (r = 0; r < 4; r++) begin
			wr(`MSC_ADDR_CFG0, `MSC_CFG0_RST | 32'(r));
			wr(`MSC_ADDR_CMD, 32'(`MSC_OP_INIT));
			n_sg = 0;
			n_ts = 0;
			wr(`MSC_ADDR_CMD, 32'(`MSC_OP_START));
			for (held = 0; held < 2000 && n_sg < 18; held++) tick;
			repeat (PERIOD / 2) tick;
			check(32'(n_ts), 32'(t_exp[r]));
		end
		// Two offset slots, then subtraction
		wr(`MSC_ADDR_CFG2, 32'h00000010);
		wr(`MSC_ADDR_CFG0, `MSC_CFG0_RST | 32'h80);
		wr(`MSC_ADDR_CMD, 32'(`MSC_OP_INIT));
		rd(`MSC_ADDR_RESULT, 32'hffffffff, 32'(val_sg));
		n_sg = 0;
		wr(`MSC_ADDR_CMD, 32'(`MSC_OP_START));
		wait_for(0);
		check(32'(n_sg), 32'd3);
		val_sg <= val_sg + 24'h000123;
		repeat (3 * PERIOD) tick;
		rd(`MSC_ADDR_RESULT, 32'hffffffff, 32'h00000123);
		// One-shot: offset start is silent, next start flags and idles
		wr(`MSC_ADDR_CFG2, 32'h0);
		wr(`MSC_ADDR_CFG0, `MSC_CFG0_RST | 32'h84);
		wr(`MSC_ADDR_CMD, 32'(`MSC_OP_INIT));
		rd(`MSC_ADDR_RESULT, 32'hffffffff, 32'h00000123);
		n_sg = 0;
		wr(`MSC_ADDR_CMD, 32'(`MSC_OP_START));
		wait_for(1);
		check(32'(int_flag), 32'h0);
		wr(`MSC_ADDR_CMD, 32'(`MSC_OP_START));
		wait_for(1);
		check(32'(int_flag), 32'h1);
		repeat (2 * PERIOD) tick;
		check(32'(n_sg), 32'd2);
		rd(`MSC_ADDR_RESULT, 32'hffffffff, 32'h0);
		tick;
		tick;
		end_of_test;
	end
endmodule : msc_seq_test
